// File: rtl/tad_ctrl_pkg.sv
// Constants, field layouts and carrier types for the aperture delay control block.
// Assumes a byte-addressed register port with 24-bit registers, clocked by the sampled device clock.
package tad_ctrl_pkg;

    localparam logic [9:0] ADDR_CAL_STATUS = 10'h2b2;
    localparam logic [9:0] ADDR_DELAY_CTRL = 10'h2b5;
    localparam logic [23:0] RESET_CAL_STATUS = 24'h000000;
    localparam logic [23:0] RESET_DELAY_CTRL = 24'h000000;
    localparam int DONE_BIT = 17;
    localparam int INV_BIT = 16;
    localparam int COARSE_LSB = 8;
    localparam int FINE_LSB = 0;
    localparam int RAMP_PERIOD_CYCLES = 384;
    localparam int UPDATE_WAIT_CYCLES = 1536;
    localparam logic [7:0] RAMP_STEP_SLOW = 8'h01;
    localparam logic [7:0] RAMP_STEP_FAST = 8'h04;
    localparam logic [10:0] RAMP_PERIOD_LAST = 11'(RAMP_PERIOD_CYCLES - 1);
    // Direct update taken at half the allowed bound, well inside the limit
    localparam logic [10:0] UPDATE_WAIT_LAST = 11'(UPDATE_WAIT_CYCLES / 2 - 1);

    typedef struct packed {
        logic invert;
        logic [7:0] coarse;
        logic [7:0] fine;
    } delay_setting_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } cal_state_e;

endpackage : tad_ctrl_pkg

// File: rtl/coarse_stepper.sv
// Moves the applied coarse delay toward its target, ramped or in one jump.
// Assumes target and mode come from registers on the same clock.
`timescale 1ns/1ps
module coarse_stepper
    import tad_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] target,
    input wire logic target_written,
    input wire logic ramp_enable,
    input wire logic ramp_fast,
    output logic [7:0] applied
);
    logic [10:0] count;
    logic [10:0] next_count;
    logic [7:0] next_applied;
    logic pending;
    logic next_pending;
    logic [7:0] step;
    logic [7:0] diff;

    always_comb
    begin
        step = ramp_fast ? RAMP_STEP_FAST : RAMP_STEP_SLOW;
        next_applied = applied;
        next_count = count;
        next_pending = pending | target_written;
        if (ramp_enable)
        begin
            // Ramp keeps moving on its own tick whether or not a write is pending
            next_pending = 1'b0;
            if (count == RAMP_PERIOD_LAST)
            begin
                next_count = '0;
                if (target > applied)
                begin
                    diff = 8'(target - applied);
                    next_applied = (diff < step) ? target : 8'(applied + step);
                end
                else
                begin
                    diff = 8'(applied - target);
                    next_applied = (diff < step) ? target : 8'(applied - step);
                end
            end
            else
            begin
                diff = '0;
                next_count = 11'(count + 11'h001);
            end
        end
        else
        begin
            diff = '0;
            if (target_written)
                next_count = '0;
            else if (pending && count == UPDATE_WAIT_LAST)
            begin
                next_applied = target;
                next_pending = 1'b0;
                next_count = '0;
            end
            else if (pending)
                next_count = 11'(count + 11'h001);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            applied <= RESET_DELAY_CTRL[15:8];
            count <= '0;
            pending <= 1'b0;
        end
        else
        begin
            applied <= next_applied;
            count <= next_count;
            pending <= next_pending;
        end
    end
endmodule : coarse_stepper

// File: rtl/aperture_delay_adjust_ctrl.sv
// Register port, calibration handshake and delay selection for the sampling aperture.
// Assumes a synchronous register port on CLOCK and an external calibration engine.
`timescale 1ns/1ps
module aperture_delay_adjust_ctrl
    import tad_ctrl_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    input wire logic [9:0] REG_ADDR,
    input wire logic [23:0] REG_WDATA,
    output logic [23:0] REG_RDATA,
    input wire logic SYSREF_CAL_ENABLE,
    input wire logic RAMP_ENABLE,
    input wire logic RAMP_FAST,
    input wire logic CAL_FINISHED,
    input wire logic [16:0] CAL_RESULT,
    output logic CAL_START,
    output logic CLOCK_INVERT,
    output logic [7:0] COARSE_DELAY,
    output logic [7:0] FINE_DELAY
);
    ////////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [23:0] delay_ctrl;
    logic [23:0] next_delay_ctrl;
    logic [16:0] cal_delay_result;
    logic [16:0] next_cal_delay_result;
    logic cal_done_flag;
    logic [23:0] next_rdata;
    logic coarse_written;
    logic cal_en_prev;
    logic next_cal_en_prev;
    logic enable_rise;
    logic ctrl_write;
    logic ctrl_read;
    logic status_read;
    cal_state_e state;
    cal_state_e next_state;
    logic next_start;
    logic [7:0] stepped_coarse;
    delay_setting_s manual;
    delay_setting_s chosen;
    delay_setting_s held;
    logic next_invert;
    logic [7:0] next_coarse;
    logic [7:0] next_fine;

    function automatic logic hit(input logic [9:0] addr, input logic [9:0] target);
        hit = (addr == target);
    endfunction : hit

    // Reserved bits 23:18 always read as zero
    function automatic logic [23:0] status_word(input logic done, input logic [16:0] result);
        status_word = {6'h00, done, result};
    endfunction : status_word

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode
    always_comb
    begin
        ctrl_write = REG_WRITE && hit(REG_ADDR, ADDR_DELAY_CTRL);
        ctrl_read = REG_READ && hit(REG_ADDR, ADDR_DELAY_CTRL);
        status_read = REG_READ && hit(REG_ADDR, ADDR_CAL_STATUS);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control and read-back registers
    // Status writes fall through unused, since the status word is read-only
    always_comb
    begin
        next_delay_ctrl = delay_ctrl;
        coarse_written = 1'b0;
        if (ctrl_write)
        begin
            next_delay_ctrl = {7'h00, REG_WDATA[16:0]};
            coarse_written = 1'b1;
        end
        // Read data stands until the next read strobe
        next_rdata = REG_RDATA;
        if (status_read)
            next_rdata = status_word(cal_done_flag, cal_delay_result);
        else if (ctrl_read)
            next_rdata = delay_ctrl;
        else if (REG_READ)
            next_rdata = 24'h000000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Calibration sequence
    always_comb
    begin
        next_state = state;
        next_start = 1'b0;
        next_cal_delay_result = cal_delay_result;
        next_cal_en_prev = SYSREF_CAL_ENABLE;
        case (state)
            ST_IDLE:
            begin
                if (enable_rise)
                begin
                    next_state = ST_RUN;
                    next_start = 1'b1;
                end
            end
            ST_RUN:
            begin
                if (!SYSREF_CAL_ENABLE)
                    next_state = ST_IDLE;
                else if (CAL_FINISHED)
                begin
                    next_state = ST_DONE;
                    next_cal_delay_result = CAL_RESULT;
                end
            end
            ST_DONE:
            begin
                // Later finished pulses are ignored until the enable is cycled
                if (!SYSREF_CAL_ENABLE)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // Gated by the live enable, so a clear hides a stale result at once
    assign cal_done_flag = (state == ST_DONE) && SYSREF_CAL_ENABLE;

    // Rise is judged against the level sampled one edge earlier
    assign enable_rise = SYSREF_CAL_ENABLE && !cal_en_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // Delay selection
    // Only the coarse path can glitch the clock, so only it is paced
    coarse_stepper u_stepper (
        .clk(CLOCK),
        .rstn(RSTN),
        .target(delay_ctrl[15:8]),
        .target_written(coarse_written),
        .ramp_enable(RAMP_ENABLE),
        .ramp_fast(RAMP_FAST),
        .applied(stepped_coarse)
    );

    always_comb
    begin
        manual.invert = delay_ctrl[INV_BIT];
        manual.coarse = stepped_coarse;
        manual.fine = delay_ctrl[7:0];
        held.invert = CLOCK_INVERT;
        held.coarse = COARSE_DELAY;
        held.fine = FINE_DELAY;
        chosen = manual;
        // Hold last setting while a calibration runs, then use its result
        if (SYSREF_CAL_ENABLE)
        begin
            if (state == ST_DONE)
                chosen = cal_delay_result;
            else
                chosen = held;
        end
        next_invert = chosen.invert;
        next_coarse = chosen.coarse;
        next_fine = chosen.fine;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file state
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            delay_ctrl <= RESET_DELAY_CTRL;
            REG_RDATA <= 24'h000000;
        end
        else
        begin
            delay_ctrl <= next_delay_ctrl;
            REG_RDATA <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Calibration state
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            cal_delay_result <= RESET_CAL_STATUS[16:0];
            state <= ST_IDLE;
            // An enable already high when reset lifts counts as a rise
            cal_en_prev <= 1'b0;
            CAL_START <= 1'b0;
        end
        else
        begin
            cal_delay_result <= next_cal_delay_result;
            state <= next_state;
            cal_en_prev <= next_cal_en_prev;
            CAL_START <= next_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Applied delay state
    // Outputs are registered so the delay line never sees a decode hazard
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            CLOCK_INVERT <= RESET_DELAY_CTRL[INV_BIT];
            COARSE_DELAY <= RESET_DELAY_CTRL[15:8];
            FINE_DELAY <= RESET_DELAY_CTRL[7:0];
        end
        else
        begin
            CLOCK_INVERT <= next_invert;
            COARSE_DELAY <= next_coarse;
            FINE_DELAY <= next_fine;
        end
    end
endmodule : aperture_delay_adjust_ctrl

// File: testbench/tad_ctrl_sva.sv
// Port-level checker for the aperture delay control block.
// Assumes every port is sampled on CLOCK with synchronous active-low RSTN.
`timescale 1ns/1ps
module tad_ctrl_sva
    import tad_ctrl_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    input wire logic [9:0] REG_ADDR,
    input wire logic [23:0] REG_WDATA,
    input wire logic [23:0] REG_RDATA,
    input wire logic SYSREF_CAL_ENABLE,
    input wire logic RAMP_ENABLE,
    input wire logic CAL_FINISHED,
    input wire logic [16:0] CAL_RESULT,
    input wire logic CAL_START,
    input wire logic CLOCK_INVERT,
    input wire logic [7:0] COARSE_DELAY,
    input wire logic [7:0] FINE_DELAY
);
default clocking cb @(posedge CLOCK); endclocking
default disable iff (!RSTN);
////////////////////////////////////////////////////////////////////////////////
sequence s_stat_rd;
    REG_READ && REG_ADDR == ADDR_CAL_STATUS;
endsequence
sequence s_man_wr;
    REG_WRITE && REG_ADDR == ADDR_DELAY_CTRL && !SYSREF_CAL_ENABLE ##1 (!SYSREF_CAL_ENABLE)[*2];
endsequence
sequence s_cal_fin;
    CAL_START ##1 CAL_FINISHED && SYSREF_CAL_ENABLE ##1 SYSREF_CAL_ENABLE;
endsequence
////////////////////////////////////////////////////////////////////////////////
chk_start_pulse: assert property ($rose(SYSREF_CAL_ENABLE) |=> CAL_START)
    else $error("no start pulse after enable rise");
chk_start_cause: assert property (CAL_START |-> $past(SYSREF_CAL_ENABLE) && !$past(SYSREF_CAL_ENABLE, 2))
    else $error("start pulse without enable rise");
chk_fine_manual: assert property (s_man_wr |-> FINE_DELAY == $past(REG_WDATA[7:0], 2))
    else $error("fine delay not taken from control write");
chk_invert_manual: assert property (s_man_wr |-> CLOCK_INVERT == $past(REG_WDATA[INV_BIT], 2))
    else $error("inversion not taken from control write");
chk_status_done: assert property (s_stat_rd |=> REG_RDATA[23:18] == 6'h00 && (!REG_RDATA[DONE_BIT] || $past(SYSREF_CAL_ENABLE)))
    else $error("done flag set without enable");
chk_done_restart: assert property ($rose(SYSREF_CAL_ENABLE) ##1 s_stat_rd |=> !REG_RDATA[DONE_BIT])
    else $error("stale done flag after restart");
chk_result_read: assert property (s_cal_fin ##0 s_stat_rd |=> REG_RDATA[17:0] == {1'b1, $past(CAL_RESULT, 2)})
    else $error("status does not show calibration result");
chk_result_drive: assert property (s_cal_fin |=> {CLOCK_INVERT, COARSE_DELAY, FINE_DELAY} == $past(CAL_RESULT, 2))
    else $error("outputs do not follow calibration result");
chk_coarse_step: assert property (RAMP_ENABLE && $past(RAMP_ENABLE) && !SYSREF_CAL_ENABLE && !$past(SYSREF_CAL_ENABLE)
    && $changed(COARSE_DELAY) |-> 8'(COARSE_DELAY - $past(COARSE_DELAY) + 8'h04) <= 8'h08)
    else $error("ramped coarse step too large");
endmodule : tad_ctrl_sva
bind aperture_delay_adjust_ctrl tad_ctrl_sva u_sva (.CLOCK(CLOCK), .RSTN(RSTN), .REG_WRITE(REG_WRITE),
    .REG_READ(REG_READ), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .SYSREF_CAL_ENABLE(SYSREF_CAL_ENABLE), .RAMP_ENABLE(RAMP_ENABLE), .CAL_FINISHED(CAL_FINISHED),
    .CAL_RESULT(CAL_RESULT), .CAL_START(CAL_START), .CLOCK_INVERT(CLOCK_INVERT),
    .COARSE_DELAY(COARSE_DELAY), .FINE_DELAY(FINE_DELAY));

// File: testbench/testbench.sv
// Self-checking bench for the aperture delay control block.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
module testbench
    import tad_ctrl_pkg::*;
;
logic CLOCK, RSTN = 0, REG_WRITE = 0, REG_READ = 0, SYSREF_CAL_ENABLE = 0;
logic RAMP_ENABLE = 0, RAMP_FAST = 0, CAL_FINISHED = 0, CAL_START, CLOCK_INVERT;
logic [9:0] REG_ADDR = '0;
logic [23:0] REG_WDATA = '0, REG_RDATA, rd_val;
logic [16:0] CAL_RESULT = '0;
logic [7:0] COARSE_DELAY, FINE_DELAY;
int n_fail = 0, n_compared = 0, cycles = 0;
delay_setting_s res = '{invert: 1'b1, coarse: 8'h5a, fine: 8'hc3};
wire [23:0] outs = {7'h00, CLOCK_INVERT, COARSE_DELAY, FINE_DELAY};
aperture_delay_adjust_ctrl u_dut (.CLOCK(CLOCK), .RSTN(RSTN), .REG_WRITE(REG_WRITE), .REG_READ(REG_READ),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SYSREF_CAL_ENABLE(SYSREF_CAL_ENABLE),
    .RAMP_ENABLE(RAMP_ENABLE), .RAMP_FAST(RAMP_FAST), .CAL_FINISHED(CAL_FINISHED), .CAL_RESULT(CAL_RESULT),
    .CAL_START(CAL_START), .CLOCK_INVERT(CLOCK_INVERT), .COARSE_DELAY(COARSE_DELAY), .FINE_DELAY(FINE_DELAY));
////////////////////////////////////////////////////////////////////////////////
task automatic tick(input int n = 1);
    repeat (n) @(posedge CLOCK);
    #10;
endtask : tick
task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
        n_fail++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask : check
task automatic wr(input logic [9:0] a, input logic [23:0] d);
    REG_WRITE = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    tick();
    REG_WRITE = 1'b0;
endtask : wr
task automatic rd(input logic [9:0] a);
    REG_READ = 1'b1;
    REG_ADDR = a;
    tick();
    REG_READ = 1'b0;
    rd_val = REG_RDATA;
endtask : rd
task automatic complete_run;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask : complete_run
////////////////////////////////////////////////////////////////////////////////
task automatic test_manual;
    rd(10'h3ff);
    check(rd_val, 24'h000000);
    tick();
    rd(ADDR_DELAY_CTRL);
    check(rd_val, RESET_DELAY_CTRL);
    wr(ADDR_CAL_STATUS, 24'hffffff);
    rd(ADDR_CAL_STATUS);
    check(rd_val, RESET_CAL_STATUS);
    // Ones above bit 16 must be dropped by the control register
    wr(ADDR_DELAY_CTRL, 24'hff053c);
    tick();
    check(outs, 24'h01003c);
    rd(ADDR_DELAY_CTRL);
    check(rd_val, 24'h01053c);
    tick(UPDATE_WAIT_CYCLES);
    check(outs, 24'h01053c);
    wr(ADDR_DELAY_CTRL, 24'h0005a0);
    tick();
    check(outs, 24'h0005a0);
    $display("test_manual done");
endtask : test_manual
task automatic test_ramp;
    logic [7:0] tgt;
    RAMP_ENABLE = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
        RAMP_FAST = i[0];
        tgt = i[0] ? 8'h0f : 8'h07;
        wr(ADDR_DELAY_CTRL, {8'h00, tgt, 8'ha0});
        // Two steps are needed, so the target cannot be reached in 200 cycles
        tick(200);
        check({23'h0, COARSE_DELAY == tgt}, 24'h0);
        tick(2 * RAMP_PERIOD_CYCLES);
        check(outs, {8'h00, tgt, 8'ha0});
    end
    $display("test_ramp done");
endtask : test_ramp
task automatic test_cal;
    RAMP_ENABLE = 1'b0;
    SYSREF_CAL_ENABLE = 1'b1;
    tick();
    check({23'h0, CAL_START}, 24'h1);
    rd(ADDR_CAL_STATUS);
    check({23'h0, rd_val[DONE_BIT]}, 24'h0);
    CAL_FINISHED = 1'b1;
    CAL_RESULT = res;
    tick();
    CAL_FINISHED = 1'b0;
    rd(ADDR_CAL_STATUS);
    check(rd_val, {6'h00, 1'b1, res});
    wr(ADDR_DELAY_CTRL, 24'h000a11);
    tick(3);
    check(outs, {7'h00, res});
    SYSREF_CAL_ENABLE = 1'b0;
    rd(ADDR_CAL_STATUS);
    check({23'h0, rd_val[DONE_BIT]}, 24'h0);
    tick(UPDATE_WAIT_CYCLES);
    check(outs, 24'h000a11);
    $display("test_cal done");
endtask : test_cal
////////////////////////////////////////////////////////////////////////////////
initial
begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
end
always @(posedge CLOCK)
begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
        n_fail++;
        complete_run();
    end
end
initial
begin
    tick(12);
    RSTN = 1'b1;
    test_manual();
    test_ramp();
    test_cal();
    complete_run();
end
endmodule : testbench
